/* hdl/hbp_regs.svh */
// Constants for the host bus port with daisy-chained interrupt logic
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH
`define HBP_MASTER_CTRL_IDX  2'h3
`define HBP_VECTOR_IDX       2'h2
`define HBP_STATUS_IDX       2'h1
`define HBP_DATA_IDX         2'h0
`define HBP_SW_RESET_VAL     8'hc0
`define HBP_CMD_CLR_PEND     8'h01
`define HBP_CMD_CLR_SERVICE  8'h02
`define HBP_CMD_LOWER_DIS    8'h04
`define HBP_CMD_LOWER_EN     8'h08
`define HBP_CMD_RST_TX_PEND  8'h10
`define HBP_VECTOR_RST       8'h00
`define HBP_SETTLE_NS        40
`define HBP_CLK_NS           8
`define HBP_SETTLE_CYC       ((`HBP_SETTLE_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`endif

/* hdl/hbp_pkg.sv */
// Types for the host bus port
package hbp_pkg;
  typedef struct packed {
    logic       chipSelN;
    logic       readN;
    logic       writeN;
    logic       irqAcknowledgeN;
    logic       chanSel;
    logic       ctrlDataSel;
  } hbp_strobe_s;
  typedef struct packed {
    logic txEmpty;
    logic rxAvail;
    logic errDet;
    logic statChg;
  } hbp_cause_s;
  typedef enum logic [1:0] {IDLE, SETTLE, OWNED, DONE} hbp_ack_e;
  typedef logic [7:0] hbp_byte_t;
endpackage

/* hdl/hbp_sync.sv */
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module hbp_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // Levels
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  // Only the second stage reads the first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q  <= INIT;
      syncOut <= INIT;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

/* hdl/hbp_host_port.sv */
// Host bus port with register select and daisy-chained interrupt
`timescale 1ns/1ps
`include "hbp_regs.svh"
// Operation
// RULE_01: Drive data bus only on read/vector
// RULE_02: Selects choose the internal register
// RULE_03: Host asserts chip select only for I/O
// RULE_04: Read strobe drives selected register out
// RULE_05: Write strobe captures bus into register
// RULE_06: Both strobes together reset chip
// RULE_07: Acknowledge read returns interrupt vector
// RULE_08: Active-low open-drain interrupt request
// RULE_09: Chain enable in and chain out
// RULE_10: Strobes pass through synchronisers
// RULE_11: Host holds selects stable during read
// RULE_12: Host holds write data across strobe
// RULE_13: No new request during acknowledge
// RULE_14: Causes set the pending flag
// RULE_15: Acknowledge leaves pending flag unchanged
// RULE_16: Command or cause removal clears pending
// RULE_17: Service set only if pending, enabled
// RULE_18: Only software clears the service flag
// RULE_19: Host maps four locations C0h-C3h
// RULE_20: Chain out follows idle/acknowledge table
// RULE_21: Command forces chain out low
// RULE_22: Writing C0h to control resets chip
// RULE_23: Request when pending, enabled, not serviced
// RULE_24: Let chain settle before owning acknowledge
module hbp_host_port
  import hbp_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Host bus pins
  input  wire hbp_pkg::hbp_strobe_s hostPins,
  input  wire hbp_pkg::hbp_byte_t   dataIn,
  output hbp_pkg::hbp_byte_t        dataOut,
  output logic                      dataOe,
  // Interrupt pins
  output logic                      irqReqOut,
  output logic                      irqReqOe,
  input  wire logic                 chainEnableIn,
  output logic                      chainEnableOut,
  // Channel side
  input  wire hbp_pkg::hbp_cause_s  causeSet,
  input  wire hbp_pkg::hbp_byte_t   rxData,
  input  wire hbp_pkg::hbp_byte_t   statusIn,
  output logic                      rxReadPulse,
  output logic                      txWritePulse,
  output hbp_pkg::hbp_byte_t        txData,
  output logic                      chipResetPulse
);
  import hbp_pkg::*;

  localparam int SETTLE_CYC = `HBP_SETTLE_CYC;

  hbp_strobe_s pins;
  logic        ieiSync;
  logic [1:0]  regIdx;
  logic        rdAct;
  logic        wrAct;
  logic        ackAct;
  logic        hwReset;
  logic        swReset;
  logic        rdAct_q;
  logic        wrAct_q;
  logic        wrEdge;
  logic        rdEdge;
  hbp_cause_s  pend_q;
  logic        anyPend;
  logic        inService_q;
  logic        lowerDis_q;
  hbp_byte_t   vector_q;
  hbp_ack_e    ack_q;
  logic [3:0]  settle_q;
  hbp_byte_t   rdData;
  hbp_byte_t   dataSync;
  hbp_cause_s  pendClr;

  // All pin inputs pass two flops first
  hbp_sync #(.W(7), .INIT(7'h7f)) uSync ( // RULE_10
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn ({hostPins, chainEnableIn}),
    .syncOut ({pins, ieiSync})
  );

  // Data bus passes two flops; it is stable across the strobe
  hbp_sync #(.W(8), .INIT(8'h00)) uDataSync ( // RULE_10
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .asyncIn (dataIn),
    .syncOut (dataSync)
  );

  // Decoded synchronised strobes
  assign regIdx  = {pins.chanSel, pins.ctrlDataSel}; // RULE_02
  assign hwReset = !pins.readN && !pins.writeN; // RULE_06
  assign rdAct   = !pins.chipSelN && !pins.readN && pins.writeN
                   && pins.irqAcknowledgeN; // RULE_04
  assign wrAct   = !pins.chipSelN && !pins.writeN && pins.readN;
  assign ackAct  = !pins.irqAcknowledgeN;
  assign wrEdge  = wrAct && !wrAct_q;
  assign rdEdge  = rdAct && !rdAct_q;
  assign swReset = wrEdge && regIdx == `HBP_MASTER_CTRL_IDX
                   && dataSync == `HBP_SW_RESET_VAL; // RULE_22
  assign anyPend = |pend_q;
  assign chipResetPulse = hwReset || swReset;

  // Strobe history for edge detection
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdAct_q <= 1'b0;
      wrAct_q <= 1'b0;
    end else begin
      rdAct_q <= rdAct;
      wrAct_q <= wrAct;
    end
  end

  // Acknowledge cycle: settle, then decide ownership
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q    <= IDLE;
      settle_q <= 4'h0;
    end else begin
      case (ack_q)
        IDLE: begin
          settle_q <= 4'h0;
          if (ackAct) ack_q <= SETTLE;
        end
        SETTLE: begin
          if (!ackAct) ack_q <= IDLE;
          else if (settle_q < 4'(SETTLE_CYC)) settle_q <= settle_q + 4'h1; // RULE_24
          else if (!pins.readN)
            ack_q <= (ieiSync && anyPend && !inService_q) ? OWNED : DONE; // RULE_17
        end
        OWNED:   if (!ackAct) ack_q <= IDLE;
        DONE:    if (!ackAct) ack_q <= IDLE;
        default: ack_q <= IDLE;
      endcase
    end
  end

  // Clear requests for the pending flags
  always_comb begin
    pendClr = '0;
    if (wrEdge && regIdx == `HBP_MASTER_CTRL_IDX) begin
      if (dataSync == `HBP_CMD_CLR_PEND) pendClr = '1; // RULE_16
      if (dataSync == `HBP_CMD_RST_TX_PEND) pendClr.txEmpty = 1'b1;
    end
    if (wrEdge && regIdx == `HBP_DATA_IDX) pendClr.txEmpty = 1'b1;
    if (rdEdge && regIdx == `HBP_DATA_IDX) pendClr.rxAvail = 1'b1;
  end

  // Pending flags; set wins over clear, acknowledge never clears
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= '0;
    end else if (chipResetPulse) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pendClr) | causeSet; // RULE_14 RULE_15
    end
  end

  // Service flag set by owned acknowledge, cleared only by command or by chip reset from both strobes or a C0h control write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      inService_q <= 1'b0;
    end else if (chipResetPulse) begin
      inService_q <= 1'b0;
    end else if (ack_q == SETTLE && !pins.readN && ackAct
                 && settle_q >= 4'(SETTLE_CYC)
                 && ieiSync && anyPend && !inService_q) begin
      inService_q <= 1'b1; // RULE_17
    end else if (wrEdge && regIdx == `HBP_MASTER_CTRL_IDX
                 && dataSync == `HBP_CMD_CLR_SERVICE) begin
      inService_q <= 1'b0; // RULE_18
    end
  end

  // Writable control, vector and transmit data
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowerDis_q   <= 1'b0;
      vector_q     <= `HBP_VECTOR_RST;
      txData       <= 8'h00;
      txWritePulse <= 1'b0;
    end else if (chipResetPulse) begin
      lowerDis_q   <= 1'b0;
      vector_q     <= `HBP_VECTOR_RST;
      txWritePulse <= 1'b0;
    end else begin
      txWritePulse <= wrEdge && regIdx == `HBP_DATA_IDX; // RULE_05
      if (wrEdge && regIdx == `HBP_DATA_IDX) txData <= dataSync;
      if (wrEdge && regIdx == `HBP_VECTOR_IDX) vector_q <= dataSync;
      if (wrEdge && regIdx == `HBP_MASTER_CTRL_IDX) begin
        if (dataSync == `HBP_CMD_LOWER_DIS) lowerDis_q <= 1'b1; // RULE_21
        if (dataSync == `HBP_CMD_LOWER_EN)  lowerDis_q <= 1'b0;
      end
    end
  end

  // Read mux for register data
  always_comb begin
    case (regIdx)
      `HBP_DATA_IDX:   rdData = rxData;
      `HBP_STATUS_IDX: rdData = {statusIn[7:6], inService_q, lowerDis_q,
                                 pend_q};
      `HBP_VECTOR_IDX: rdData = vector_q;
      default:         rdData = {6'h00, inService_q, anyPend};
    endcase
  end

  // Data bus drive registered; floats outside read and owned vector
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOut     <= 8'h00;
      dataOe      <= 1'b0;
      rxReadPulse <= 1'b0;
    end else begin
      rxReadPulse <= rdEdge && regIdx == `HBP_DATA_IDX;
      if (ack_q == OWNED && !pins.readN) begin
        dataOut <= vector_q; // RULE_07
        dataOe  <= 1'b1;
      end else if (rdAct) begin
        dataOut <= rdData; // RULE_04
        dataOe  <= 1'b1;
      end else begin
        dataOe  <= 1'b0; // RULE_01
      end
    end
  end

  // Interrupt request and chain out
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqReqOe       <= 1'b0;
      chainEnableOut <= 1'b0;
    end else begin
      irqReqOe <= anyPend && ieiSync && !inService_q
                  && ack_q == IDLE && !ackAct; // RULE_08 RULE_13 RULE_23
      if (lowerDis_q) chainEnableOut <= 1'b0;
      else if (ackAct)
        chainEnableOut <= ieiSync && !anyPend && !inService_q; // RULE_20
      else chainEnableOut <= ieiSync && !inService_q; // RULE_09
    end
  end
  assign irqReqOut = 1'b0; // Open drain: only pulls low

  // Checks
  chk_bus_float: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rdAct && ack_q != OWNED) |=> !dataOe) // RULE_01
    else $error("data bus driven outside read");
  chk_irq_quiet_ack: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ackAct |=> !irqReqOe) // RULE_13
    else $error("request raised during acknowledge");
  chk_ack_keeps_pend: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    (ack_q == OWNED && !chipResetPulse && causeSet == '0 && !wrEdge
     && !rdEdge) |=> pend_q == $past(pend_q)) // RULE_15
    else $error("acknowledge altered pending");
  chk_service_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (inService_q && !chipResetPulse && !wrEdge) |=> inService_q) // RULE_18
    else $error("service flag cleared without command");
  chk_service_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(inService_q) |-> $past(ieiSync) && $past(anyPend)) // RULE_17
    else $error("service set without pending and enable");
  chk_lower_dis: assert property (@(posedge ref_clk) disable iff (!rst_b)
    lowerDis_q |=> !chainEnableOut) // RULE_21
    else $error("chain out high while lower disabled");
  chk_chain_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!ieiSync || inService_q) |=> !chainEnableOut) // RULE_20
    else $error("chain out high with input low or serviced");
  chk_irq_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irqReqOe |-> $past(anyPend) && $past(ieiSync)) // RULE_23
    else $error("request without pending and enable");
  chk_sw_reset: assert property (@(posedge ref_clk) disable iff (!rst_b)
    swReset |=> !inService_q && pend_q == '0) // RULE_22
    else $error("soft reset did not clear flags");
  chk_strobe_reset: assert property (@(posedge ref_clk) disable iff (!rst_b)
    hwReset |=> !inService_q && !lowerDis_q && pend_q == '0) // RULE_06
    else $error("joint strobes did not reset");
  chk_chain_ack: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ackAct && anyPend) |=> !chainEnableOut) // RULE_20
    else $error("chain out high while pending in acknowledge");
  // Owned acknowledge read: vector goes out on the next edge
  sequence s_owned_read;
    ack_q == OWNED && !pins.readN && pins.writeN;
  endsequence
  chk_vector_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_owned_read |=> dataOe && dataOut == $past(vector_q)) // RULE_07
    else $error("vector not driven in acknowledge");
endmodule

/* tb/hbp_host_model.sv */
// Host processor bus model for the host bus port
`timescale 1ns/1ps
module hbp_host_model
  import hbp_pkg::*;
(
  // Clock
  input  wire logic               ref_clk,
  // Bus pins
  output hbp_pkg::hbp_strobe_s    hostPins,
  output hbp_pkg::hbp_byte_t      dataIn,
  input  wire hbp_pkg::hbp_byte_t dataOut,
  input  wire logic               dataOe
);
  hbp_byte_t drv;
  hbp_byte_t lastBus;
  logic      drvOe;
  // Floating bus shows a changing pattern, never a stale byte
  assign dataIn = dataOe ? dataOut : (drvOe ? drv : ~lastBus);
  always @(posedge ref_clk) lastBus <= dataIn;
  initial begin
    hostPins = 6'h3c;
    drv = 8'h00;
    drvOe = 1'b0;
    lastBus = 8'h5a;
  end
  // One strobed cycle; ack cycles keep chip select off
  task automatic cyc(input logic [1:0] idx, input logic rdN, input logic wrN,
                     input logic ackN, input hbp_byte_t d,
                     output hbp_byte_t q, output logic oe);
    @(negedge ref_clk);
    hostPins = {~ackN, 2'b11, ackN, idx};
    drv = d;
    drvOe = !wrN;
    repeat (ackN ? 1 : 9) @(negedge ref_clk);
    hostPins.readN = rdN;
    hostPins.writeN = wrN;
    repeat (6) @(negedge ref_clk);
    q = dataIn;
    oe = dataOe;
    hostPins.readN = 1'b1;
    hostPins.writeN = 1'b1;
    repeat (4) @(negedge ref_clk);
    drvOe = 1'b0;
    hostPins = 6'h3c;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module tb_top;
  import hbp_pkg::*;
  logic        ref_clk, rst_b, chainEnableIn, oe;
  logic        dataOe, irqReqOut, irqReqOe, chainEnableOut;
  logic        rxReadPulse, txWritePulse, chipResetPulse;
  hbp_strobe_s hostPins;
  hbp_cause_s  causeSet;
  hbp_byte_t   dataIn, dataOut, txData, rxData, statusIn, q, d, w, vec;
  int          miscompares, checked, cycles, nTx, nRx, nRst, pend, svc, lowDis;
  logic [7:0]  cmds [5] = '{8'h04, 8'h02, 8'h08, 8'h10, 8'h01};

  hbp_host_port hbp_host_port_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .hostPins(hostPins), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .irqReqOut(irqReqOut), .irqReqOe(irqReqOe), .chainEnableIn(chainEnableIn),
    .chainEnableOut(chainEnableOut), .causeSet(causeSet), .rxData(rxData),
    .statusIn(statusIn), .rxReadPulse(rxReadPulse), .txData(txData),
    .txWritePulse(txWritePulse), .chipResetPulse(chipResetPulse));
  hbp_host_model bus (.ref_clk(ref_clk), .hostPins(hostPins), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe));

  // Free-running 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Pulse counters and hang guard
  always @(negedge ref_clk) begin
    cycles++;
    if (txWritePulse === 1'b1) begin
      nTx++;
      w = txData;
    end
    if (rxReadPulse === 1'b1) nRx++;
    if (chipResetPulse === 1'b1) nRst++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Model view of the status byte
  function automatic logic [7:0] stat();
    return {statusIn[7:6], svc[0], lowDis[0], pend[3:0]};
  endfunction
  task automatic cause(input hbp_cause_s c);
    @(negedge ref_clk) causeSet = c;
    @(negedge ref_clk) causeSet = '0;
    pend |= c;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic rdStat();
    bus.cyc(2'h1, 1'b0, 1'b1, 1'b1, 8'h00, q, oe);
    chk("status", stat(), q);
  endtask

  initial begin
    {rst_b, causeSet} = '0;
    chainEnableIn = 1'b1;
    void'($urandom(54539));
    {rxData, statusIn, vec, d} = $urandom;
    repeat (5) @(negedge ref_clk);
    chk("oe in reset", 8'h00, {7'h0, dataOe});
    rst_b = 1'b1;
    chk("irq level", 8'h00, {7'h0, irqReqOut});
    // Data write, data read, vector write and read back
    bus.cyc(2'h0, 1'b1, 1'b0, 1'b1, d, q, oe);
    chk("tx data", d, w);
    chk("tx pulses", 8'h01, 8'(nTx));
    bus.cyc(2'h0, 1'b0, 1'b1, 1'b1, 8'h00, q, oe);
    chk("rx data", rxData, q);
    chk("rx pulses", 8'h01, 8'(nRx));
    bus.cyc(2'h2, 1'b1, 1'b0, 1'b1, vec, q, oe);
    bus.cyc(2'h2, 1'b0, 1'b1, 1'b1, 8'h00, q, oe);
    chk("vector", vec, q);
    $display("test access done");
    // Pending causes raise the request
    cause(4'hc);
    chk("irq on", 8'h01, {7'h0, irqReqOe});
    rdStat();
    // Chain input low: no request, no ownership
    chainEnableIn = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("irq off", 8'h00, {7'h0, irqReqOe});
    chk("chain out", 8'h00, {7'h0, chainEnableOut});
    bus.cyc(2'h0, 1'b0, 1'b1, 1'b0, 8'h00, q, oe);
    chk("no vector", 8'h00, {7'h0, oe});
    chainEnableIn = 1'b1;
    // Owned acknowledge returns vector, sets service, keeps pending
    bus.cyc(2'h0, 1'b0, 1'b1, 1'b0, 8'h00, q, oe);
    chk("ack oe", 8'h01, {7'h0, oe});
    chk("ack vector", vec, q);
    svc = 1;
    chk("irq served", 8'h00, {7'h0, irqReqOe});
    rdStat();
    $display("test acknowledge done");
    // Control commands
    foreach (cmds[i]) begin
      bus.cyc(2'h3, 1'b1, 1'b0, 1'b1, cmds[i], q, oe);
      case (cmds[i])
        8'h01: pend = 0;
        8'h02: svc = 0;
        8'h04: lowDis = 1;
        8'h08: lowDis = 0;
        default: pend &= 7;
      endcase
      repeat (3) @(negedge ref_clk);
      chk("chain", 8'(!svc && !lowDis), {7'h0, chainEnableOut});
      chk("irq", 8'(pend != 0 && !svc), {7'h0, irqReqOe});
      rdStat();
    end
    // Data read removes the receive cause
    cause(4'h4);
    bus.cyc(2'h0, 1'b0, 1'b1, 1'b1, 8'h00, q, oe);
    pend = 0;
    rdStat();
    $display("test commands done");
    // Soft reset, then both strobes together
    cause(4'h2);
    bus.cyc(2'h3, 1'b1, 1'b0, 1'b1, 8'hc0, q, oe);
    chk("soft reset", 8'h01, 8'(nRst != 0));
    pend = 0;
    rdStat();
    nRst = 0;
    bus.cyc(2'h0, 1'b0, 1'b0, 1'b1, 8'h00, q, oe);
    chk("strobe reset", 8'h01, 8'(nRst != 0));
    $display("test reset done");
    report_and_stop();
  end
endmodule
